/* File: fwbl_pkg.sv */
// Behaviour
// RULE_01: Memory capability read returns max packet, erase time, write time, checksum.
// RULE_02: Host sizes packets and spaces commands from the reported figures.
// RULE_03: Application status read returns one status byte for the chosen target.
// RULE_04: Status bits: erased, checksum bad, sequence, address, downstream, in loader.
// RULE_05: Host reads application status after every upgrade command.
// RULE_06: Loader control carries target and data: enter, erase, done, exit.
// RULE_07: Target byte is ignored for enter and exit requests.
// RULE_08: Loader switches the main output off while it runs.
// RULE_09: Host waits at least one second after erase.
// RULE_10: After erase the status shows in loader plus erased.
// RULE_11: Upload starts with packet sequence number zero.
// RULE_12: Sequence increments per accepted packet; read gives seq low, high, status.
// RULE_13: Appended status equals the application status byte.
// RULE_14: Host restarts the download when the appended status shows an error.
// RULE_15: Host starts each packet with the last returned sequence number.
// RULE_16: Done request runs CRC-16 over the image, checked against its last two bytes.
// RULE_17: Host waits at least one second after done before querying.
// RULE_18: Passing check leaves only the in-loader bit set.
// RULE_19: Exit runs the application only when all images are valid.
// RULE_20: After exit the target list query returns a zero status byte.
// RULE_21: Product code read returns a count, eleven bytes and PEC.
// RULE_22: Any reprogramming error blocks the application start.
// RULE_23: Upgrade commands work only after the four-letter unlock string.
// RULE_24: Target byte is ASCII p, s or i.
// RULE_25: Writes with a bad PEC are ignored; reads get a correct PEC appended.
package fwbl_pkg;
  localparam logic [7:0] CMD_UNLOCK = 8'he0;
  localparam logic [7:0] CMD_TARGETS = 8'he1;
  localparam logic [7:0] CMD_MEMCAP = 8'he4;
  localparam logic [7:0] CMD_APPSTAT = 8'he5;
  localparam logic [7:0] CMD_LOADER = 8'he6;
  localparam logic [7:0] CMD_XFER = 8'he7;
  localparam logic [7:0] CMD_PRODID = 8'he8;
  localparam logic [7:0] OP_ENTER = 8'h01;
  localparam logic [7:0] OP_ERASE = 8'h02;
  localparam logic [7:0] OP_DONE = 8'h03;
  localparam logic [7:0] OP_EXIT = 8'h04;
  localparam logic [7:0] TGT_PRI = 8'h70;
  localparam logic [7:0] TGT_SEC = 8'h73;
  localparam logic [7:0] TGT_IFC = 8'h69;
  localparam logic [31:0] UNLOCK_WORD = 32'h55504744;
  localparam logic [7:0] UNLOCK_LEN = 8'h04;
  localparam logic [7:0] ST_ERASED = 8'h01;
  localparam logic [7:0] ST_CRC_BAD = 8'h02;
  localparam logic [7:0] ST_SEQ_BAD = 8'h04;
  localparam logic [7:0] ST_ADDR_BAD = 8'h08;
  localparam logic [7:0] ST_DOWNSTREAM = 8'h40;
  localparam logic [7:0] ST_IN_LOADER = 8'h80;
  localparam logic [7:0] RLEN_STAT = 8'h01;
  localparam logic [7:0] RLEN_MEMCAP = 8'h08;
  localparam logic [7:0] RLEN_XFER = 8'h04;
  localparam logic [7:0] RLEN_PRODID = 8'h0c;
  localparam logic [7:0] CNT_MEMCAP = 8'h07;
  localparam logic [7:0] CNT_XFER = 8'h03;
  localparam logic [7:0] CNT_PRODID = 8'h0b;
  localparam logic [7:0] ERASED_FILL = 8'hff;
  localparam logic [7:0] PEC_INIT = 8'h00;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SEQ = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    FWBL_IDLE = 2'b00,
    FWBL_ERASE = 2'b01,
    FWBL_CRC = 2'b11,
    FWBL_CHK = 2'b10
  } fwbl_state_t;
endpackage : fwbl_pkg

/* File: fwbl_crc16.sv */
`timescale 1ns/100ps
module fwbl_crc16
  import fwbl_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Async reset, active low
  input wire logic clr, // Restart from init value
  input wire logic en, // Fold in din
  input wire logic [7:0] din, // Image byte
  output logic [15:0] crc // Running CRC-16
);
  typedef struct packed {
    logic [15:0] crc;
  } fwbl_crc_t;
  fwbl_crc_t q;
  fwbl_crc_t next_q;

  function automatic logic [15:0] fwbl_step(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      r = r[15] ? ((r << 1) ^ CRC16_POLY) : (r << 1);
    end
    return r;
  endfunction : fwbl_step

  always_comb
  begin
    next_q = q;
    if (clr)
      next_q.crc = CRC16_INIT;
    else if (en)
      next_q.crc = fwbl_step(q.crc, din);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      q <= '{crc: CRC16_INIT};
    else
      q <= next_q;
  end

  assign crc = q.crc;
endmodule : fwbl_crc16

/* File: fwbl_top.sv */
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module fwbl_top
  import fwbl_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter logic [6:0] SLAVE_ADDR = 7'h58,
  parameter logic [7:0] SELF_TGT = TGT_PRI,
  parameter logic [7:0] MAX_PKT = 8'h20,
  parameter logic [15:0] ERASE_MS = 16'd1000,
  parameter logic [15:0] WRITE_US = 16'd100,
  parameter logic [87:0] PROD_ID = 88'h0102030405060708090a0b // Arbitrary
)
(
  input wire logic ref_clk, // 200 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic frm_start, // Start of frame, address matched
  input wire logic wr_valid, // Written byte strobe
  input wire logic [7:0] wr_byte, // Written byte
  input wire logic rd_start, // Repeated start for read
  input wire logic rd_req, // Master wants next read byte
  input wire logic frm_stop, // Stop condition
  output logic rd_valid, // Read byte strobe
  output logic [7:0] rd_byte, // Read byte
  output logic main_off_req, // Force main output off
  output logic app_run, // Application in control
  input wire logic [3:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI
  output logic s_axi_awready, // AXI
  input wire logic [31:0] s_axi_wdata, // AXI
  input wire logic [3:0] s_axi_wstrb, // AXI
  input wire logic s_axi_wvalid, // AXI
  output logic s_axi_wready, // AXI
  output logic [1:0] s_axi_bresp, // AXI
  output logic s_axi_bvalid, // AXI
  input wire logic s_axi_bready, // AXI
  input wire logic [3:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI
  output logic s_axi_arready, // AXI
  output logic [31:0] s_axi_rdata, // AXI
  output logic [1:0] s_axi_rresp, // AXI
  output logic s_axi_rvalid, // AXI
  input wire logic s_axi_rready // AXI
);
  typedef struct packed {
    fwbl_state_t st;
    logic [7:0] cmd, tgt, arg, cnt, idx, ridx, pend, pidx, crc, crc_prev;
    logic pend_v, pw_ok, unlocked, in_boot, erased, crc_err, seq_err;
    logic addr_err, app_ok, app_run, off, ovf, rd_valid;
    logic [7:0] rd_byte;
    logic [15:0] seq, pseq;
    logic [AW:0] wptr, pptr, cidx;
    logic [1:0] ctrl;
    logic aw_got, w_got, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [3:0] awa;
    logic [31:0] wd, rdata;
    logic [3:0] wstrb;
  } fwbl_core_t;
  fwbl_core_t q;
  fwbl_core_t next_q;

  logic [7:0] mem [DEPTH];
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic crc_clr, crc_en;
  logic [15:0] crc16;
  logic [7:0] stat, cbyte, tail_hi, tail_lo;
  logic all_valid;

  function automatic logic [7:0] fwbl_pec(logic [7:0] c, logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    end
    return r;
  endfunction : fwbl_pec

  // Status byte shared by the status, list and transfer answers [RULE_04]
  always_comb
  begin
    stat = 8'h00;
    if (q.erased)
      stat = stat | ST_ERASED;
    if (q.crc_err)
      stat = stat | ST_CRC_BAD;
    if (q.seq_err)
      stat = stat | ST_SEQ_BAD;
    if (q.addr_err)
      stat = stat | ST_ADDR_BAD;
    if (q.ctrl[0])
      stat = stat | ST_DOWNSTREAM;
    if (q.in_boot)
      stat = stat | ST_IN_LOADER;
  end

  assign all_valid = q.app_ok && q.ctrl[1] && !q.erased && !q.crc_err
    && !q.seq_err && !q.addr_err; // [RULE_19] [RULE_22]
  assign cbyte = mem[q.cidx[AW-1:0]];
  assign tail_hi = mem[AW'(q.wptr - 2)];
  assign tail_lo = mem[AW'(q.wptr - 1)];

  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  fwbl_crc16 u_crc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clr(crc_clr),
    .en(crc_en),
    .din(cbyte),
    .crc(crc16)
  );

  always_comb
  begin
    logic [7:0] b;
    logic [7:0] pi;
    logic [7:0] tst;
    b = 8'h00;
    pi = 8'h00;
    tst = 8'h00;
    next_q = q;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 8'h00;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    next_q.rd_valid = 1'b0;
    tst = (q.tgt == SELF_TGT) ? stat : 8'h00; // [RULE_24]
    // Commit of the previous byte; the newest one may still be the PEC
    if ((wr_valid || rd_start) && q.pend_v)
    begin
      b = q.pend;
      pi = q.pidx;
      case (pi)
        8'h00: next_q.cmd = b;
        8'h01:
        begin
          next_q.tgt = b;
          next_q.cnt = b;
        end
        8'h02:
        begin
          next_q.arg = b;
          next_q.pseq[7:0] = b;
        end
        8'h03: next_q.pseq[15:8] = b;
        default: ;
      endcase
      if (q.cmd == CMD_UNLOCK && pi >= 8'h02 && pi <= 8'h05)
        if (b != UNLOCK_WORD[8'(8'h05 - pi)*8 +: 8])
          next_q.pw_ok = 1'b0;
      if (q.cmd == CMD_XFER && pi >= 8'h04)
      begin
        if (q.pptr < (AW+1)'(DEPTH))
        begin
          mem_we = 1'b1;
          mem_wa = q.pptr[AW-1:0];
          mem_wd = b;
          next_q.pptr = q.pptr + 1'b1;
        end
        else
          next_q.ovf = 1'b1;
      end
    end
    if (frm_start)
    begin
      next_q.crc = fwbl_pec(PEC_INIT, {SLAVE_ADDR, 1'b0});
      next_q.idx = 8'h00;
      next_q.pend_v = 1'b0;
      next_q.pw_ok = 1'b1;
      next_q.ovf = 1'b0;
      next_q.pptr = q.wptr;
    end
    else if (wr_valid)
    begin
      next_q.crc_prev = q.crc;
      next_q.crc = fwbl_pec(q.crc, wr_byte);
      next_q.pend = wr_byte;
      next_q.pidx = q.idx;
      next_q.pend_v = 1'b1;
      next_q.idx = q.idx + 8'h01;
    end
    else if (rd_start)
    begin
      next_q.crc = fwbl_pec(q.crc, {SLAVE_ADDR, 1'b1});
      next_q.pend_v = 1'b0;
      next_q.ridx = 8'h00;
    end
    else if (rd_req)
    begin
      case (q.cmd)
        CMD_APPSTAT, CMD_TARGETS:
        begin
          b = (q.ridx == 8'h00) ? tst : q.crc; // [RULE_03] [RULE_20]
          pi = RLEN_STAT;
        end
        CMD_MEMCAP: // [RULE_01]
        begin
          pi = RLEN_MEMCAP;
          case (q.ridx)
            8'h00: b = CNT_MEMCAP;
            8'h01: b = MAX_PKT;
            8'h02: b = ERASE_MS[7:0];
            8'h03: b = ERASE_MS[15:8];
            8'h04: b = WRITE_US[7:0];
            8'h05: b = WRITE_US[15:8];
            8'h06: b = crc16[7:0];
            8'h07: b = crc16[15:8];
            default: b = q.crc;
          endcase
        end
        CMD_XFER: // [RULE_12] [RULE_13]
        begin
          pi = RLEN_XFER;
          case (q.ridx)
            8'h00: b = CNT_XFER;
            8'h01: b = q.seq[7:0];
            8'h02: b = q.seq[15:8];
            8'h03: b = stat;
            default: b = q.crc;
          endcase
        end
        CMD_PRODID: // [RULE_21]
        begin
          pi = RLEN_PRODID;
          if (q.ridx == 8'h00)
            b = CNT_PRODID;
          else if (q.ridx < RLEN_PRODID)
            b = PROD_ID[8'(RLEN_PRODID - 8'h01 - q.ridx)*8 +: 8];
          else
            b = q.crc;
        end
        default:
        begin
          pi = 8'h00;
          b = ERASED_FILL;
        end
      endcase
      if (q.ridx > pi)
        b = ERASED_FILL;
      next_q.rd_byte = b; // PEC closes the answer [RULE_25]
      next_q.rd_valid = 1'b1;
      next_q.crc = fwbl_pec(q.crc, b);
      next_q.ridx = q.ridx + 8'h01;
    end
    else if (frm_stop && q.pend_v && q.pend == q.crc_prev) // [RULE_25]
    begin
      next_q.pend_v = 1'b0;
      if (q.cmd == CMD_UNLOCK && q.cnt == UNLOCK_LEN && q.idx == 8'h07
          && q.pw_ok)
        next_q.unlocked = 1'b1; // [RULE_23]
      else if (q.cmd == CMD_LOADER && q.unlocked && q.st == FWBL_IDLE
               && q.idx == 8'h04)
      begin
        // Enter and exit act whatever the target byte says [RULE_07]
        case (q.arg)
          OP_ENTER: // [RULE_06]
          begin
            next_q.in_boot = 1'b1;
            next_q.app_run = 1'b0;
            next_q.seq = 16'h0000; // [RULE_11]
            next_q.seq_err = 1'b0;
            next_q.addr_err = 1'b0;
          end
          OP_ERASE:
            if (q.in_boot && q.tgt == SELF_TGT)
            begin
              next_q.st = FWBL_ERASE;
              next_q.cidx = '0;
            end
          OP_DONE:
            if (q.in_boot && q.tgt == SELF_TGT)
            begin
              next_q.st = FWBL_CRC;
              next_q.cidx = '0;
              crc_clr = 1'b1;
            end
          OP_EXIT:
            if (q.in_boot && all_valid) // [RULE_19] [RULE_22]
            begin
              next_q.in_boot = 1'b0;
              next_q.app_run = 1'b1;
              next_q.unlocked = 1'b0;
            end
          default: ;
        endcase
      end
      // Packet byte 1 is a length, not a target, so no target test here
      else if (q.cmd == CMD_XFER && q.unlocked && q.in_boot
               && q.st == FWBL_IDLE)
      begin
        if (q.pseq != q.seq) // [RULE_11]
          next_q.seq_err = 1'b1;
        else if (q.ovf)
          next_q.addr_err = 1'b1;
        else
        begin
          next_q.seq = q.seq + 16'h0001; // [RULE_12]
          next_q.wptr = q.pptr;
          next_q.erased = 1'b0;
          next_q.app_ok = 1'b0;
        end
      end
    end
    else if (frm_stop)
      next_q.pend_v = 1'b0; // Bad PEC: frame dropped silently
    case (q.st)
      FWBL_ERASE:
      begin
        mem_we = 1'b1;
        mem_wa = q.cidx[AW-1:0];
        mem_wd = ERASED_FILL;
        next_q.cidx = q.cidx + 1'b1;
        if (q.cidx == (AW+1)'(DEPTH - 1))
        begin
          next_q.st = FWBL_IDLE;
          next_q.erased = 1'b1; // [RULE_10]
          next_q.crc_err = 1'b0;
          next_q.seq_err = 1'b0;
          next_q.addr_err = 1'b0;
          next_q.app_ok = 1'b0;
          next_q.wptr = '0;
          next_q.seq = 16'h0000;
        end
      end
      FWBL_CRC: // Image bytes minus the stored tail [RULE_16]
        if (q.wptr < (AW+1)'(3))
          next_q.st = FWBL_CHK;
        else if (q.cidx == q.wptr - (AW+1)'(2))
          next_q.st = FWBL_CHK;
        else
        begin
          crc_en = 1'b1;
          next_q.cidx = q.cidx + 1'b1;
        end
      FWBL_CHK:
      begin
        next_q.st = FWBL_IDLE;
        if (q.wptr >= (AW+1)'(3) && crc16 == {tail_hi, tail_lo})
        begin
          next_q.crc_err = 1'b0; // [RULE_18]
          next_q.app_ok = 1'b1;
        end
        else
          next_q.crc_err = 1'b1;
      end
      default: ;
    endcase
    next_q.off = next_q.in_boot; // [RULE_08]
    // AXI4-Lite slave, one write and one read in flight
    if (s_axi_awvalid && q.awready)
    begin
      next_q.aw_got = 1'b1;
      next_q.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      next_q.w_got = 1'b1;
      next_q.wd = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      next_q.bvalid = 1'b0;
    else if (q.aw_got && q.w_got && !q.bvalid)
    begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OKAY;
      if (q.awa == REG_CTRL)
      begin
        if (q.wstrb[0])
          next_q.ctrl = q.wd[1:0];
      end
      else if (q.awa != REG_STATUS && q.awa != REG_SEQ)
        next_q.bresp = RESP_SLVERR;
    end
    next_q.awready = !next_q.aw_got && !next_q.bvalid;
    next_q.wready = !next_q.w_got && !next_q.bvalid;
    if (q.rvalid && s_axi_rready)
      next_q.rvalid = 1'b0;
    else if (s_axi_arvalid && q.arready)
    begin
      next_q.rvalid = 1'b1;
      next_q.rresp = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: next_q.rdata = {30'h0, q.ctrl};
        REG_STATUS: next_q.rdata = {20'h0, q.st, q.app_run, q.unlocked, stat};
        REG_SEQ: next_q.rdata = {(16-AW-1)'(0), q.wptr, q.seq};
        default:
        begin
          next_q.rdata = 32'h0;
          next_q.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_q.arready = !next_q.rvalid;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.st <= FWBL_IDLE;
      q.app_ok <= 1'b1;
      q.app_run <= 1'b1;
    end
    else
      q <= next_q;
  end

  assign rd_valid = q.rd_valid;
  assign rd_byte = q.rd_byte;
  assign main_off_req = q.off;
  assign app_run = q.app_run;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_out_off;
    q.in_boot |-> main_off_req && !app_run;
  endproperty
  a_p_out_off: assert property (p_out_off) else $error("output left on"); // [RULE_08]
  property p_erase_stat;
    q.st == FWBL_ERASE ##1 q.st == FWBL_IDLE |-> (stat & 8'hbf) == 8'h81;
  endproperty
  a_p_erase_stat: assert property (p_erase_stat) else $error("erase status"); // [RULE_10]
  property p_crc_pass;
    q.st == FWBL_CHK && q.wptr >= 3 && crc16 == {tail_hi, tail_lo}
      |=> (stat & 8'hbf) == 8'h80;
  endproperty
  a_p_crc_pass: assert property (p_crc_pass) else $error("crc pass status"); // [RULE_18]
  property p_seq_step;
    $changed(q.seq) |-> q.seq == $past(q.seq) + 16'h0001 || q.seq == 16'h0000;
  endproperty
  a_p_seq_step: assert property (p_seq_step) else $error("seq jump"); // [RULE_12]
  property p_exit_guard;
    $rose(app_run) |-> $past(all_valid);
  endproperty
  a_p_exit_guard: assert property (p_exit_guard) else $error("bad exit"); // [RULE_19]
  property p_reserved;
    stat[5:4] == 2'b00;
  endproperty
  a_p_reserved: assert property (p_reserved) else $error("reserved set"); // [RULE_04]
  property p_enter;
    $rose(q.in_boot) |-> $past(q.unlocked) && q.seq == 16'h0000;
  endproperty
  a_p_enter: assert property (p_enter) else $error("locked entry"); // [RULE_23]
  property p_rd_answer;
    rd_req && !frm_start && !wr_valid && !rd_start |=> rd_valid;
  endproperty
  a_p_rd_answer: assert property (p_rd_answer) else $error("no read byte"); // [RULE_01]
  c_erase: cover property (q.st == FWBL_ERASE ##1 q.st == FWBL_IDLE);
  c_crc_ok: cover property (q.st == FWBL_CHK ##1 !q.crc_err);
  c_exit: cover property ($rose(app_run));
endmodule : fwbl_top

/* File: fwbl_host.sv */
`timescale 1ns/100ps
module fwbl_host #(
  parameter logic [6:0] ADDR = 7'h58
)
(
  input wire logic ref_clk, // Clock
  output logic frm_start, // Frame start
  output logic wr_valid, // Byte strobe
  output logic [7:0] wr_byte, // Byte
  output logic rd_start, // Repeated start
  output logic rd_req, // Next read byte
  output logic frm_stop // Stop
);
  initial
  begin
    {frm_start, wr_valid, rd_start, rd_req, frm_stop} = '0;
    wr_byte = 8'h00;
  end
  function automatic logic [7:0] pec(input logic [7:0] p, input logic [7:0] b);
    logic [7:0] c;
    c = p ^ b;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : pec
  task automatic ev(input int k);
    @(posedge ref_clk);
    case (k)
      0: frm_start <= 1'b1;
      1: rd_start <= 1'b1;
      2: rd_req <= 1'b1;
      default: frm_stop <= 1'b1;
    endcase
    @(posedge ref_clk);
    {frm_start, rd_start, rd_req, frm_stop} <= '0;
  endtask : ev
  task automatic put(input logic [7:0] b);
    @(posedge ref_clk);
    wr_valid <= 1'b1;
    wr_byte <= b;
    @(posedge ref_clk);
    wr_valid <= 1'b0;
    wr_byte <= ~b; // Idle lane never repeats the last byte
  endtask : put
  task automatic wr(input logic [7:0] b[$], input bit corrupt);
    logic [7:0] p;
    p = pec(8'h00, {ADDR, 1'b0});
    ev(0);
    foreach (b[i])
    begin
      put(b[i]);
      p = pec(p, b[i]);
    end
    put(corrupt ? ~p : p);
    ev(3);
  endtask : wr
  task automatic rd(input logic [7:0] b[$], input int n);
    ev(0);
    foreach (b[i]) put(b[i]);
    ev(1);
    repeat (n) ev(2);
    ev(3);
  endtask : rd
endmodule : fwbl_host

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench
  import fwbl_pkg::*;
;
  localparam int DEPTH = 64;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic frm_start, wr_valid, rd_start, rd_req, frm_stop;
  logic [7:0] wr_byte, rd_byte;
  logic rd_valid, main_off_req, app_run;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int bad_count = 0;
  int check_count = 0;
  logic [7:0] exp_q[$];
  logic [7:0] img[$];
  logic [7:0] pkt[$];
  logic [31:0] seed = 32'd80740;
  logic [15:0] crc;
  always #2.5 ref_clk = ~ref_clk;
  fwbl_top #(.DEPTH(DEPTH), .PROD_ID(88'h0102030405060504030201)) uut (
    .ref_clk, .rstn, .frm_start, .wr_valid, .wr_byte, .rd_start, .rd_req,
    .frm_stop, .rd_valid, .rd_byte, .main_off_req, .app_run,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  fwbl_host u_host (.ref_clk, .frm_start, .wr_valid, .wr_byte, .rd_start,
    .rd_req, .frm_stop);
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  always @(posedge ref_clk)
    if (rd_valid === 1'b1)
      chk(exp_q.size() ? {24'h0, exp_q.pop_front()} : 32'h1ff, {24'h0, rd_byte});
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC16_INIT;
    foreach (b[i])
    begin
      c ^= {b[i], 8'h00};
      repeat (8) c = c[15] ? {c[14:0], 1'b0} ^ CRC16_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc16
  // Queues the expected bytes and read PEC, then runs the read frame
  task automatic rdx(input logic [7:0] c[$], input logic [7:0] d[$]);
    logic [7:0] p;
    p = u_host.pec(8'h00, 8'hb0);
    foreach (c[i]) p = u_host.pec(p, c[i]);
    p = u_host.pec(p, 8'hb1);
    foreach (d[i])
    begin
      exp_q.push_back(d[i]);
      p = u_host.pec(p, d[i]);
    end
    exp_q.push_back(p);
    u_host.rd(c, d.size() + 1);
    chk(32'h0, exp_q.size());
    exp_q.delete();
  endtask : rdx
  task automatic st(input logic [7:0] t, input logic [7:0] s);
    rdx('{CMD_APPSTAT, t}, '{s});
  endtask : st
  task automatic cmd(input logic [7:0] op, input logic [7:0] t, input bit bad);
    u_host.wr('{CMD_LOADER, t, op}, bad);
  endtask : cmd
  task automatic lv(input logic [1:0] e);
    repeat (2) @(posedge ref_clk);
    chk({30'h0, e}, {30'h0, main_off_req, app_run});
  endtask : lv
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) bad_count++;
    if (n == 50) report_and_stop();
    chk({30'h0, r}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) bad_count++;
    if (n == 50) report_and_stop();
    chk(d, s_axi_rdata);
    chk({30'h0, r}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic unlock();
    u_host.wr('{CMD_UNLOCK, UNLOCK_LEN, 8'h55, 8'h50, 8'h47, 8'h44}, 0);
  endtask : unlock
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    lv(2'b01);
    cmd(OP_ENTER, TGT_PRI, 0); // Still locked, so ignored
    unlock();
    st(TGT_PRI, 8'h00);
    cmd(OP_ENTER, TGT_IFC, 1);
    st(TGT_PRI, 8'h00);
    cmd(OP_ENTER, TGT_IFC, 0);
    st(TGT_PRI, ST_IN_LOADER);
    lv(2'b10);
    st(TGT_SEC, 8'h00);
    cmd(OP_ERASE, TGT_PRI, 0);
    repeat (3 * DEPTH) @(posedge ref_clk);
    st(TGT_PRI, ST_IN_LOADER | ST_ERASED);
    repeat (6)
    begin
      seed = lfsr(seed);
      img.push_back(seed[7:0]);
    end
    crc = crc16(img);
    img.push_back(crc[15:8]);
    img.push_back(crc[7:0]);
    pkt = '{CMD_XFER, 8'h0a, 8'h00, 8'h00};
    foreach (img[i]) pkt.push_back(img[i]);
    u_host.wr(pkt, 0);
    cmd(OP_DONE, TGT_PRI, 0);
    repeat (3 * DEPTH) @(posedge ref_clk);
    st(TGT_PRI, ST_IN_LOADER);
    rdx('{CMD_XFER}, '{CNT_XFER, 8'h01, 8'h00, ST_IN_LOADER});
    rdx('{CMD_MEMCAP}, '{CNT_MEMCAP, 8'h20, 8'he8, 8'h03, 8'h64, 8'h00,
      crc[7:0], crc[15:8]});
    rdx('{CMD_PRODID}, '{CNT_PRODID, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
      8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01});
    cmd(OP_EXIT, TGT_PRI, 0);
    lv(2'b10);
    axw(REG_CTRL, 32'h2, RESP_OKAY);
    axr(REG_CTRL, 32'h2, RESP_OKAY);
    axw(4'hc, 32'h1, RESP_SLVERR);
    axr(4'hc, 32'h0, RESP_SLVERR);
    cmd(OP_EXIT, TGT_SEC, 0);
    lv(2'b01);
    axr(REG_STATUS, 32'h200, RESP_OKAY);
    unlock();
    rdx('{CMD_TARGETS, TGT_PRI}, '{8'h00});
    cmd(OP_ENTER, TGT_PRI, 0);
    cmd(OP_ERASE, TGT_PRI, 0);
    repeat (3 * DEPTH) @(posedge ref_clk);
    u_host.wr('{CMD_XFER, 8'h03, 8'h03, 8'h00, 8'h11}, 0); // Wrong sequence
    st(TGT_PRI, ST_IN_LOADER | ST_ERASED | ST_SEQ_BAD);
    u_host.wr('{CMD_XFER, 8'h03, 8'h00, 8'h00, 8'h11}, 0);
    rdx('{CMD_XFER}, '{CNT_XFER, 8'h01, 8'h00, 8'h84});
    cmd(OP_EXIT, TGT_PRI, 0);
    lv(2'b10);
    report_and_stop();
  end
endmodule : testbench
